// ### gpio_upper_map.svh
/*
  Register offsets and reset values for the upper GPIO configuration bank.
  Assumes inclusion by bare name from files in the same folder.
*/
`ifndef GPIO_UPPER_MAP_SVH
`define GPIO_UPPER_MAP_SVH

`define OFS_BOTH_EDGE     12'h05C
`define OFS_PAD_CFG_A     12'h060
`define OFS_PAD_CFG_B     12'h064
`define OFS_FSEL2         12'h068
`define OFS_FSEL2_SET     12'h06C
`define OFS_FSEL2_CLR     12'h070
`define OFS_FSEL3         12'h074
`define OFS_FSEL3_SET     12'h078
`define OFS_FSEL3_CLR     12'h07C
`define OFS_HYST_RSVD     12'h0A8
`define OFS_SLEW_RSVD     12'h0AC
`define OFS_DRIVE_LO      12'h0B0
`define OFS_DRIVE_HI      12'h0B4
`define OFS_PULL_STR      12'h0B8
`define OFS_RAIL_SEL      12'h0C0
`define OFS_IRQ_KIND      12'h0D0
`define OFS_IRQ_SENSE     12'h0D4
`define OFS_IRQ_STATUS    12'h0D8
`define OFS_IN_LEVEL      12'h0DC
`define REG_RESET         32'h0000_0000
`define ADDR_WORD_LSB     2

`endif

// ### gpio_upper_pkg.sv
/*
  Shared types for the upper GPIO configuration bank.
  Assumes a 32-bit APB data path.
*/
package gpio_upper_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] offset_t;
endpackage

// ### gpio_port_upper_config_regs.sv
/*
  Upper GPIO configuration registers as an APB slave, plus per-pin interrupt
  trigger detection that uses the both-edge, trigger kind and sense words.
  Assumes pins arrive asynchronously and that interrupt enable, flag storage
  and clearing sit in a neighbouring block fed by irq_event.
*/
`timescale 1ns/1ps
`include "gpio_upper_map.svh"

module gpio_port_upper_config_regs
  import gpio_upper_pkg::*;
#(
  parameter int PINS = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [PINS-1:0]   pin_in,
  output logic      [PINS-1:0]   irq_event,
  output logic      [PINS-1:0]   pad_cfg_a,
  output logic      [PINS-1:0]   pad_cfg_b,
  output logic      [PINS-1:0]   func_sel_second,
  output logic      [PINS-1:0]   func_sel_third,
  output logic      [PINS-1:0]   drive_lo,
  output logic      [PINS-1:0]   drive_hi,
  output logic      [PINS-1:0]   pull_strong,
  output logic      [PINS-1:0]   rail_high
);

  // Every register word is one bus word wide, so only a full port fits.
  if (PINS != 32) begin : g_pins_check
    $error("PINS must be 32 to match the 32-bit register words.");
  end

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  logic        wr_en;
  logic        rd_en;
  word_t       wmask;
  offset_t     ofs;
  logic        mapped;

  assign ofs   = {paddr[11:`ADDR_WORD_LSB], 2'b00};
  assign wr_en = clk_en && psel && penable && pwrite && pready;
  assign rd_en = clk_en && psel && !penable && !pwrite;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  word_t both_edge_q, irq_kind_q, irq_sense_q;
  word_t fsel2_q, fsel3_q;
  word_t in_sync1_q, in_sync2_q, in_prev_q;
  word_t rd_d;

  always_comb begin
    mapped = 1'b1;
    case (ofs)
      `OFS_BOTH_EDGE:  rd_d = both_edge_q;
      `OFS_PAD_CFG_A:  rd_d = pad_cfg_a;
      `OFS_PAD_CFG_B:  rd_d = pad_cfg_b;
      `OFS_FSEL2:      rd_d = fsel2_q;
      `OFS_FSEL3:      rd_d = fsel3_q;
      `OFS_FSEL2_SET,
      `OFS_FSEL2_CLR,
      `OFS_FSEL3_SET,
      `OFS_FSEL3_CLR:  rd_d = `REG_RESET;
      `OFS_HYST_RSVD,
      `OFS_SLEW_RSVD:  rd_d = `REG_RESET;
      `OFS_DRIVE_LO:   rd_d = drive_lo;
      `OFS_DRIVE_HI:   rd_d = drive_hi;
      `OFS_PULL_STR:   rd_d = pull_strong;
      `OFS_RAIL_SEL:   rd_d = rail_high;
      `OFS_IRQ_KIND:   rd_d = irq_kind_q;
      `OFS_IRQ_SENSE:  rd_d = irq_sense_q;
      `OFS_IRQ_STATUS: rd_d = irq_event;
      `OFS_IN_LEVEL:   rd_d = in_sync2_q;
      default: begin
        rd_d   = `REG_RESET;
        mapped = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Bus response
  // ------------------------------------------------------------------
  // No wait states: data and error are registered in the setup cycle
  // so every output leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `REG_RESET;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en) begin
        prdata <= rd_d;
      end
    end
  end

  // ------------------------------------------------------------------
  // Plain read-write words
  // ------------------------------------------------------------------
  function automatic word_t merge(input word_t old_v, input word_t new_v, input word_t m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      both_edge_q <= `REG_RESET;
      irq_kind_q  <= `REG_RESET;
      irq_sense_q <= `REG_RESET;
      pad_cfg_a   <= `REG_RESET;
      pad_cfg_b   <= `REG_RESET;
      drive_lo    <= `REG_RESET;
      drive_hi    <= `REG_RESET;
      pull_strong <= `REG_RESET;
      rail_high   <= `REG_RESET;
    end else if (wr_en && !pslverr) begin
      case (ofs)
        `OFS_BOTH_EDGE: both_edge_q <= merge(both_edge_q, pwdata, wmask);
        `OFS_IRQ_KIND:  irq_kind_q  <= merge(irq_kind_q, pwdata, wmask);
        `OFS_IRQ_SENSE: irq_sense_q <= merge(irq_sense_q, pwdata, wmask);
        `OFS_PAD_CFG_A: pad_cfg_a   <= merge(pad_cfg_a, pwdata, wmask);
        `OFS_PAD_CFG_B: pad_cfg_b   <= merge(pad_cfg_b, pwdata, wmask);
        `OFS_DRIVE_LO:  drive_lo    <= merge(drive_lo, pwdata, wmask);
        `OFS_DRIVE_HI:  drive_hi    <= merge(drive_hi, pwdata, wmask);
        `OFS_PULL_STR:  pull_strong <= merge(pull_strong, pwdata, wmask);
        `OFS_RAIL_SEL:  rail_high   <= merge(rail_high, pwdata, wmask);
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Function select words with set and clear aliases
  // ------------------------------------------------------------------
  // Software is trusted to keep absent pins at reset; hardware does not mask them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel2_q <= `REG_RESET;
      fsel3_q <= `REG_RESET;
    end else if (wr_en && !pslverr) begin
      case (ofs)
        `OFS_FSEL2:     fsel2_q <= merge(fsel2_q, pwdata, wmask);
        `OFS_FSEL2_SET: fsel2_q <= fsel2_q | (pwdata & wmask);
        `OFS_FSEL2_CLR: fsel2_q <= fsel2_q & ~(pwdata & wmask);
        `OFS_FSEL3:     fsel3_q <= merge(fsel3_q, pwdata, wmask);
        `OFS_FSEL3_SET: fsel3_q <= fsel3_q | (pwdata & wmask);
        `OFS_FSEL3_CLR: fsel3_q <= fsel3_q & ~(pwdata & wmask);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_sel_second <= `REG_RESET;
      func_sel_third  <= `REG_RESET;
    end else if (clk_en) begin
      func_sel_second <= fsel2_q;
      func_sel_third  <= fsel3_q;
    end
  end

  // ------------------------------------------------------------------
  // Input sampling and trigger detection
  // ------------------------------------------------------------------
  // The sampling path takes no function select term, so alternate pins still
  // report levels and raise events.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sync1_q <= `REG_RESET;
      in_sync2_q <= `REG_RESET;
      in_prev_q  <= `REG_RESET;
    end else if (clk_en) begin
      in_sync1_q <= pin_in;
      in_sync2_q <= in_sync1_q;
      in_prev_q  <= in_sync2_q;
    end
  end

  word_t rise, fall, edge_hit, level_hit;

  assign rise      = in_sync2_q & ~in_prev_q;
  assign fall      = ~in_sync2_q & in_prev_q;
  assign edge_hit  = (both_edge_q & (rise | fall))
                   | (~both_edge_q & ((irq_sense_q & rise) | (~irq_sense_q & fall)));
  assign level_hit = ~(in_sync2_q ^ irq_sense_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_event <= `REG_RESET;
    end else if (clk_en) begin
      irq_event <= (irq_kind_q & edge_hit) | (~irq_kind_q & level_hit);
    end
  end

endmodule

// ### gpio_upper_checker.sv
/* Port assertions for the upper GPIO configuration bank.
   Assumes full byte strobes on checked writes and clk_en held high. */
`timescale 1ns/1ps
module gpio_upper_checker #(
  parameter int PINS = 32
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic            pready,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [3:0]      pstrb,
  input wire logic [31:0]     prdata,
  input wire logic [PINS-1:0] pad_cfg_a,
  input wire logic [PINS-1:0] pad_cfg_b,
  input wire logic [PINS-1:0] drive_hi,
  input wire logic [PINS-1:0] func_sel_second,
  input wire logic [PINS-1:0] func_sel_third,
  input wire logic [PINS-1:0] drive_lo,
  input wire logic [PINS-1:0] pull_strong,
  input wire logic [PINS-1:0] rail_high
);
  // Partial strobes are left out so the expected word is the whole bus value.
  wire logic wr = psel && penable && pready && pwrite && pstrb == 4'hF;
  wire logic rd = psel && penable && pready && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_zero: assert property ($rose(presetn) |-> (func_sel_second | func_sel_third) == 0)
    else $error("select word not zero after reset");
  chk_pad_write: assert property (wr && paddr == 12'h060 |=> pad_cfg_a == $past(pwdata))
    else $error("pad word a not written");
  chk_padb_write: assert property (wr && paddr == 12'h064 |=> pad_cfg_b == $past(pwdata))
    else $error("pad word b not written");
  chk_drivehi_write: assert property (wr && paddr == 12'h0B4 |=> drive_hi == $past(pwdata))
    else $error("drive high word not written");
  chk_drive_write: assert property (wr && paddr == 12'h0B0 |=> drive_lo == $past(pwdata))
    else $error("drive word not written");
  chk_pull_write: assert property (wr && paddr == 12'h0B8 |=> pull_strong == $past(pwdata))
    else $error("pull word not written");
  chk_rail_write: assert property (wr && paddr == 12'h0C0 |=> rail_high == $past(pwdata))
    else $error("rail word not written");
  chk_set_ones: assert property (wr && paddr == 12'h06C |->
    ##2 (func_sel_second & $past(pwdata, 2)) == $past(pwdata, 2))
    else $error("setter left a bit low");
  chk_clear_ones: assert property (wr && paddr == 12'h07C |->
    ##2 (func_sel_third & $past(pwdata, 2)) == 0)
    else $error("clearer left a bit high");
  chk_rsvd_zero: assert property (rd && paddr inside {12'h0A8, 12'h0AC} |-> prdata == 0)
    else $error("reserved word not zero");
  chk_alias_zero: assert property (rd && paddr inside {12'h06C, 12'h070, 12'h078, 12'h07C}
    |-> prdata == 0)
    else $error("alias read not zero");
endmodule
bind gpio_port_upper_config_regs gpio_upper_checker #(.PINS(PINS)) chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .pready, .paddr, .pwdata, .pstrb, .prdata, .pad_cfg_a, .pad_cfg_b, .drive_hi,
  .func_sel_second,
  .func_sel_third, .drive_lo, .pull_strong, .rail_high);

// ### pin_model.sv
/* Pin and pad side model driving the 32 input pins.
   Assumes callers step it from the pclk domain. */
`timescale 1ns/1ps
module pin_model (
  input  wire logic        pclk,
  output logic      [31:0] pin_in
);
  initial pin_in = 32'h0000_0000;
  task automatic put(input logic [31:0] v);
    @(posedge pclk);
    pin_in <= v;
  endtask
endmodule

// ### tb_top.sv
/* Self-checking bench for the upper GPIO bank over APB.
   Assumes the design, its package, the checker and the pin model compile first. */
`timescale 1ns/1ps
module tb_top;
  import gpio_upper_pkg::*;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [3:0]  pstrb = 4'hF;
  offset_t     paddr = 12'h000;
  word_t       pwdata = 32'h0000_0000, rdat, prdata, irq_event, pin_in;
  logic        pready, pslverr;
  int          errors = 0, n_tests = 0;
  offset_t     rw[9] = '{12'h05C, 12'h060, 12'h064, 12'h068, 12'h074, 12'h0B0, 12'h0B4,
                         12'h0B8, 12'h0C0};
  pin_model pins (.pclk(pclk), .pin_in(pin_in));
  gpio_port_upper_config_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .irq_event(irq_event), .pad_cfg_a(), .pad_cfg_b(), .func_sel_second(),
    .func_sel_third(), .drive_lo(), .drive_hi(), .pull_strong(), .rail_high());
  initial forever #12.5 pclk = ~pclk;
  task automatic xfer(input offset_t a, input logic w, input word_t d);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic chk(input word_t got, input word_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input offset_t a, input word_t exp);
    xfer(a, 0, 0);
    chk(rdat, exp);
  endtask
  // A pin change must hold irq_event[b] high for exactly n of the next eight cycles.
  task automatic see(input word_t p, input int b, input int n);
    int c;
    c = 0;
    pins.put(p);
    repeat (8) begin
      @(posedge pclk);
      c += (irq_event[b] === 1'b1);
    end
    chk(c, n);
  endtask
  task automatic test_done;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (rw[i]) rd(rw[i], 0);
    foreach (rw[i]) xfer(rw[i], 1, 32'h5A3C_0000 ^ rw[i]);
    foreach (rw[i]) rd(rw[i], 32'h5A3C_0000 ^ rw[i]);
    xfer(12'h0A8, 1, '1);
    rd(12'h0A8, 0);
    rd(12'h0AC, 0);
    for (int k = 0; k < 2; k++) begin
      offset_t b;
      b = 12'h068 + 12'h00C * k;
      xfer(b, 1, 32'hF0F0_00FF);
      xfer(b + 4, 1, 32'h0F00_0001);
      rd(b, 32'hFFF0_00FF);
      xfer(b + 8, 1, 32'h00F0_000F);
      rd(b, 32'hFF00_00F0);
      rd(b + 4, 0);
      rd(b + 8, 0);
    end
    rd(12'h100, 0);
    chk(rerr, 1);
    xfer(12'h078, 1, '1);
    xfer(12'h0D0, 1, 32'hFFFF_FFFB);
    xfer(12'h0D4, 1, 32'h0000_0004);
    xfer(12'h05C, 1, 32'h0000_0001);
    see(32'h0000_0001, 0, 1);
    see(32'h0000_0003, 1, 0);
    see(32'h0000_0001, 1, 1);
    see(32'h0000_0000, 0, 1);
    see(32'h0000_0004, 2, 5);
    chk(irq_event[2], 1);
    rd(12'h0DC, 32'h0000_0004);
    clk_en <= 0;
    pins.put(32'h0000_0000);
    repeat (6) @(posedge pclk);
    chk(irq_event[2], 1);
    clk_en <= 1;
    @(posedge pclk);
    test_done;
  end
endmodule
